// ==== hdl/cwf_consts.vh ====
// Constants for the continuous weight frame transmitter
// Contract
// - Line rate selectable from 300 to 9600 baud
// - Start, seven data, even parity, stop bits
// - Sixteen bytes plain, eighteen with both options
// - STX, status A B C, weight, tare, CR
// - Optional checksum byte follows carriage return
// - Leading zero digits sent as spaces
// - Status A low bits encode decimal point
// - Setpoint option puts setpoint outputs in A
// - Without setpoints, A carries increment size
// - Status byte bit 7 is its parity
// - Status B net, minus, overcapacity, motion bits
// - Status B bit 4 kilograms or other unit
// - Status B bit 6 zero tolerance or power-up
// - Status C bit 3 print, bit 5 one
`ifndef CWF_CONSTS_VH
`define CWF_CONSTS_VH
`define CWF_ADR_CTRL 4'h0
`define CWF_ADR_SCALE 4'h1
`define CWF_ADR_FLAGS 4'h2
`define CWF_ADR_WEIGHT 4'h3
`define CWF_ADR_TARE 4'h4
`define CWF_ADR_STATUS 4'h5
`define CWF_CTRL_RST 32'h0000_0051
`define CWF_SCALE_RST 32'h0000_0012
`define CWF_FLAGS_RST 32'h0000_0080
`define CWF_CTRL_EN 0
`define CWF_CTRL_STX 1
`define CWF_CTRL_RECORD_CHECKSUM_BYTE 2
`define CWF_CTRL_SP 3
`define CWF_FLAG_NET 0
`define CWF_FLAG_NEG 1
`define CWF_FLAG_OVR 2
`define CWF_FLAG_MOT 3
`define CWF_FLAG_KG 4
`define CWF_FLAG_OTHER 5
`define CWF_FLAG_ZTOL 6
`define CWF_FLAG_PWRUP 7
`define CWF_FLAG_PRINT 8
`define CWF_BAUD_MIN 300
`define CWF_BAUD_SEL_MAX 4'h5
`define CWF_CH_STX 7'h02
`define CWF_CH_CR 7'h0d
`define CWF_CH_SP 7'h20
`define CWF_CH_ZERO 7'h30
`define CWF_POS_STX 5'h00
`define CWF_POS_CR 5'h10
`define CWF_POS_RECORD_CHECKSUM_BYTE 5'h11
`endif

// ==== hdl/frame_fifo.v ====
// Synchronous FIFO between record builder and character serializer
`timescale 1ns/1ns
module frame_fifo #(
   parameter WIDTH = 7,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk_i,
   input wire rst_i,
   input wire [WIDTH-1:0] in_data_i,
   input wire in_valid_i,
   output wire in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [AW:0] level_o
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;
   assign in_ready_o = (count_reg != DEPTH[AW:0]);
   assign out_valid_o = (count_reg != {(AW+1){1'b0}});
   assign out_data_o = mem_reg[rd_ptr_reg];
   assign level_o = count_reg;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   always @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push & ~pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop & ~push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // frame_fifo

// ==== hdl/char_serializer.v ====
// Ten-bit asynchronous character transmitter with even parity
`timescale 1ns/1ns
module char_serializer #(
   parameter DIV_W = 17
) (
   input wire clk_i,
   input wire rst_i,
   input wire [DIV_W-1:0] divisor_i,
   input wire [6:0] data_i,
   input wire valid_i,
   output wire ready_o,
   output reg tx_o,
   output wire busy_o
);
   reg [9:0] shift_reg;
   reg [3:0] bits_reg;
   reg [DIV_W-1:0] tick_reg;
   assign busy_o = (bits_reg != 4'h0);
   assign ready_o = ~busy_o;
   always @(posedge clk_i) begin
      if (rst_i) begin
         shift_reg <= 10'h3ff;
         bits_reg <= 4'h0;
         tick_reg <= {DIV_W{1'b0}};
         tx_o <= 1'b1;
      end else if (!busy_o) begin
         tx_o <= 1'b1;
         if (valid_i) begin
            // Stop, even parity, seven data bits, start; sent LSB first
            shift_reg <= {1'b1, ^data_i, data_i, 1'b0};
            bits_reg <= 4'ha;
            tick_reg <= divisor_i - 1'b1;
            tx_o <= 1'b0;
         end
      end else if (tick_reg != {DIV_W{1'b0}}) begin
         tick_reg <= tick_reg - 1'b1;
      end else begin
         shift_reg <= {1'b1, shift_reg[9:1]};
         bits_reg <= bits_reg - 1'b1;
         tick_reg <= divisor_i - 1'b1;
         tx_o <= (bits_reg == 4'h1) ? 1'b1 : shift_reg[1];
      end
   end
endmodule // char_serializer

// ==== hdl/continuous_weight_frame_tx.v ====
// Continuous weight record framer with Wishbone registers
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "cwf_consts.vh"
module continuous_weight_frame_tx #(
   parameter CLK_HZ = 20000000,
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW = 5
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output wire serial_tx_o,
   output wire frame_active_o
);
   localparam S_IDLE = 2'h0;
   localparam S_LOAD = 2'h1;
   localparam S_SEND = 2'h2;

   reg [31:0] ctrl_reg;
   reg [31:0] scale_reg;
   reg [31:0] flags_reg;
   reg [23:0] weight_reg;
   reg [23:0] tare_reg;
   reg [15:0] rec_count_reg;
   reg [1:0] state_reg;
   reg [4:0] pos_reg;
   reg [6:0] sum_reg;
   reg cap_stx_reg;
   reg cap_ck_reg;
   reg cap_sp_reg;
   reg [6:0] cap_a_reg;
   reg [6:0] cap_b_reg;
   reg [6:0] cap_c_reg;
   reg [41:0] cap_w_reg;
   reg [41:0] cap_t_reg;
   reg [6:0] byte_next;
   reg [16:0] divisor_reg;

   wire wb_req;
   wire wb_wr;
   wire [3:0] wb_idx;
   wire print_set;
   wire capture;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_ready;
   wire [6:0] fifo_out_data;
   wire [FIFO_AW:0] fifo_level;
   wire push;
   wire last_pos;
   wire ser_busy;
   wire [6:0] stat_a;
   wire [6:0] stat_b;
   wire [6:0] stat_c;
   wire [3:0] baud_sel;
   wire [31:0] weight_merged;
   wire [31:0] tare_merged;
   wire [31:0] flags_merged;

   // Byte-lane merge for register writes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] din;
      input [3:0] sel;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
               merge[k*8 +: 8] = din[k*8 +: 8];
            end
         end
      end
   endfunction

   // Six BCD digits to ASCII, leading zeros blanked up to the units digit, stopping one to three digits earlier for point codes 3 to 5
   function [41:0] digits_ascii;
      input [23:0] bcd;
      input [2:0] dp_code;
      integer i;
      integer keep;
      reg lead;
      reg [3:0] d;
      begin
         digits_ascii = 42'h0;
         lead = 1'b1;
         keep = 5;
         if (dp_code > 3'h2 && dp_code < 3'h6) begin
            keep = 5 - (dp_code - 3'h2);
         end
         for (i = 0; i < 6; i = i + 1) begin
            d = bcd[(5-i)*4 +: 4];
            if (lead && d == 4'h0 && i < keep) begin
               digits_ascii[(5-i)*7 +: 7] = `CWF_CH_SP;
            end else begin
               lead = 1'b0;
               digits_ascii[(5-i)*7 +: 7] = `CWF_CH_ZERO | {3'h0, d};
            end
         end
      end
   endfunction

   // Replaceable checksum stage: two's complement of seven-bit sum
   function [6:0] record_checksum_byte;
      input [6:0] sum;
      begin
         record_checksum_byte = 7'h00 - sum;
      end
   endfunction

   // Clock cycles per bit for 300 shifted left by the rate select, capped at 5
   function [16:0] baud_divisor;
      input [3:0] sel;
      reg [3:0] s;
      reg [31:0] rate;
      reg [31:0] quot;
      begin
         s = (sel > `CWF_BAUD_SEL_MAX) ? `CWF_BAUD_SEL_MAX : sel;
         rate = `CWF_BAUD_MIN << s;
         quot = CLK_HZ / rate;
         baud_divisor = quot[16:0];
      end
   endfunction

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_req & wb_we_i;
   assign wb_idx = wb_adr_i[5:2];
   assign baud_sel = ctrl_reg[7:4];
   assign print_set = wb_wr && wb_idx == `CWF_ADR_FLAGS && wb_sel_i[1] && wb_dat_i[8];
   assign weight_merged = merge({8'h0, weight_reg}, wb_dat_i, wb_sel_i);
   assign tare_merged = merge({8'h0, tare_reg}, wb_dat_i, wb_sel_i);
   assign flags_merged = merge(flags_reg, wb_dat_i, wb_sel_i);

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl_reg <= `CWF_CTRL_RST;
         scale_reg <= `CWF_SCALE_RST;
         weight_reg <= 24'h0;
         tare_reg <= 24'h0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            case (wb_idx)
               `CWF_ADR_CTRL: wb_dat_o <= ctrl_reg;
               `CWF_ADR_SCALE: wb_dat_o <= scale_reg;
               `CWF_ADR_FLAGS: wb_dat_o <= flags_reg;
               `CWF_ADR_WEIGHT: wb_dat_o <= {8'h0, weight_reg};
               `CWF_ADR_TARE: wb_dat_o <= {8'h0, tare_reg};
               `CWF_ADR_STATUS: begin
                  wb_dat_o <= {rec_count_reg, 3'h0, fifo_level, pos_reg, ser_busy,
                     (state_reg != S_IDLE)};
               end
               default: wb_dat_o <= 32'h0;
            endcase
         end
         if (wb_wr) begin
            case (wb_idx)
               `CWF_ADR_CTRL: ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_00ff;
               `CWF_ADR_SCALE: scale_reg <= merge(scale_reg, wb_dat_i, wb_sel_i) & 32'h0000_007f;
               `CWF_ADR_WEIGHT: weight_reg <= weight_merged[23:0];
               `CWF_ADR_TARE: tare_reg <= tare_merged[23:0];
               default: ctrl_reg <= ctrl_reg;
            endcase
         end
      end
   end

   // Flags register; a print request set by software wins over the capture clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         flags_reg <= `CWF_FLAGS_RST;
      end else begin
         if (wb_wr && wb_idx == `CWF_ADR_FLAGS) begin
            // An untouched print bit is still cleared by a capture in the same cycle
            flags_reg <= {23'h0, flags_merged[8] & ~(capture & ~print_set), flags_merged[7:0]};
         end else if (capture && !print_set) begin
            flags_reg[`CWF_FLAG_PRINT] <= 1'b0;
         end
      end
   end

   assign stat_a[2:0] = scale_reg[2:0];
   assign stat_a[4:3] = ctrl_reg[`CWF_CTRL_SP] ? scale_reg[6:5] : scale_reg[4:3];
   assign stat_a[5] = 1'b1;
   assign stat_a[6] = ctrl_reg[`CWF_CTRL_SP];
   assign stat_b[3:0] = flags_reg[3:0];
   assign stat_b[4] = flags_reg[`CWF_FLAG_KG] | flags_reg[`CWF_FLAG_OTHER];
   assign stat_b[5] = 1'b1;
   assign stat_b[6] = ctrl_reg[`CWF_CTRL_SP] ? flags_reg[`CWF_FLAG_ZTOL] :
      flags_reg[`CWF_FLAG_PWRUP];
   assign stat_c = {3'h2, flags_reg[`CWF_FLAG_PRINT], 3'h0};

   assign capture = (state_reg == S_LOAD);
   assign push = (state_reg == S_SEND) & fifo_in_ready;
   assign last_pos = cap_ck_reg ? (pos_reg == `CWF_POS_RECORD_CHECKSUM_BYTE) : (pos_reg == `CWF_POS_CR);
   assign frame_active_o = (state_reg != S_IDLE) | fifo_out_valid | ser_busy;

   // Record byte for the current position
   always @* begin
      byte_next = `CWF_CH_SP;
      case (pos_reg)
         5'h00: byte_next = `CWF_CH_STX;
         5'h01: byte_next = cap_a_reg;
         5'h02: byte_next = cap_b_reg;
         5'h03: byte_next = cap_c_reg;
         5'h04: byte_next = cap_w_reg[41:35];
         5'h05: byte_next = cap_w_reg[34:28];
         5'h06: byte_next = cap_w_reg[27:21];
         5'h07: byte_next = cap_w_reg[20:14];
         5'h08: byte_next = cap_w_reg[13:7];
         5'h09: byte_next = cap_w_reg[6:0];
         5'h0a: byte_next = cap_t_reg[41:35];
         5'h0b: byte_next = cap_t_reg[34:28];
         5'h0c: byte_next = cap_t_reg[27:21];
         5'h0d: byte_next = cap_t_reg[20:14];
         5'h0e: byte_next = cap_t_reg[13:7];
         5'h0f: byte_next = cap_t_reg[6:0];
         5'h10: byte_next = `CWF_CH_CR;
         5'h11: byte_next = record_checksum_byte(sum_reg);
         default: byte_next = `CWF_CH_SP;
      endcase
   end

   // Record sequencer
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= S_IDLE;
         pos_reg <= 5'h0;
         sum_reg <= 7'h0;
         cap_stx_reg <= 1'b0;
         cap_ck_reg <= 1'b0;
         cap_sp_reg <= 1'b0;
         cap_a_reg <= 7'h0;
         cap_b_reg <= 7'h0;
         cap_c_reg <= 7'h0;
         cap_w_reg <= 42'h0;
         cap_t_reg <= 42'h0;
         rec_count_reg <= 16'h0;
         divisor_reg <= 17'h1;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (ctrl_reg[`CWF_CTRL_EN]) begin
                  state_reg <= S_LOAD;
               end
            end
            S_LOAD: begin
               // Snapshot so each record is self-consistent
               cap_stx_reg <= ctrl_reg[`CWF_CTRL_STX];
               cap_ck_reg <= ctrl_reg[`CWF_CTRL_RECORD_CHECKSUM_BYTE];
               cap_sp_reg <= ctrl_reg[`CWF_CTRL_SP];
               cap_a_reg <= stat_a;
               cap_b_reg <= stat_b;
               cap_c_reg <= stat_c;
               cap_w_reg <= digits_ascii(weight_reg, scale_reg[2:0]);
               cap_t_reg <= digits_ascii(tare_reg, scale_reg[2:0]);
               divisor_reg <= baud_divisor(baud_sel);
               pos_reg <= ctrl_reg[`CWF_CTRL_STX] ? `CWF_POS_STX : 5'h01;
               sum_reg <= 7'h0;
               state_reg <= S_SEND;
            end
            S_SEND: begin
               if (push) begin
                  sum_reg <= sum_reg + byte_next;
                  if (last_pos) begin
                     rec_count_reg <= rec_count_reg + 1'b1;
                     // Next record follows directly while enabled
                     state_reg <= ctrl_reg[`CWF_CTRL_EN] ? S_LOAD : S_IDLE;
                  end else begin
                     pos_reg <= pos_reg + 1'b1;
                  end
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   frame_fifo #(
      .WIDTH(7),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_data_i(byte_next),
      .in_valid_i(state_reg == S_SEND),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .level_o(fifo_level)
   );

   char_serializer #(
      .DIV_W(17)
   ) u_ser (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .divisor_i(divisor_reg),
      .data_i(fifo_out_data),
      .valid_i(fifo_out_valid),
      .ready_o(fifo_out_ready),
      .tx_o(serial_tx_o),
      .busy_o(ser_busy)
   );
endmodule // continuous_weight_frame_tx

// ==== dv/cwf_asserts.sv ====
// Checker on the ports of the continuous weight frame transmitter
`timescale 1ns/1ns
module cwf_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic serial_tx_o,
   input wire logic frame_active_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_reset_idle;
      $fell(rst_i) |-> serial_tx_o && !wb_ack_o && wb_dat_o == 32'h0;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("reset state wrong");
   property p_idle_high;
      !frame_active_o |-> serial_tx_o;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line not idle high");
   property p_unmapped;
      wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[5:2] > 4'h5
         |=> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_first_record;
      $fell(rst_i) |-> ##[1:12] !serial_tx_o;
   endproperty
   a_first_record: assert property (p_first_record) else $error("no start bit");
   property p_dat_hold;
      !(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o);
   endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
endmodule // cwf_asserts
bind continuous_weight_frame_tx cwf_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .serial_tx_o(serial_tx_o), .frame_active_o(frame_active_o));

// ==== dv/serial_rx_model.sv ====
// Serial receiver standing in for the host on the far side
`timescale 1ns/1ns
module serial_rx_model (
   input wire clk_i,
   input wire rx_i,
   input wire [5:0] bit_clks_i,
   output reg [6:0] data_o,
   output reg valid_o,
   output reg bad_o
);
   reg [9:0] sh = 10'h0;
   integer cnt = 0;
   integer nb = 0;
   initial begin
      data_o = 7'h00;
      valid_o = 1'b0;
      bad_o = 1'b0;
   end
   // Samples each bit at its first clock, start first, ten bits a character
   always @(posedge clk_i) begin
      valid_o <= 1'b0;
      if (nb == 0) begin
         if (rx_i === 1'b0) begin
            sh[0] = 1'b0;
            nb = 1;
            cnt = 1;
         end
      end else if (cnt < bit_clks_i) begin
         cnt = cnt + 1;
      end else begin
         cnt = 1;
         sh[nb] = rx_i;
         nb = nb + 1;
         if (nb == 10) begin
            nb = 0;
            data_o <= sh[7:1];
            bad_o <= (^sh[8:1]) | ~sh[9];
            valid_o <= 1'b1;
         end
      end
   end
endmodule // serial_rx_model

// ==== dv/tb_top.sv ====
// Self-checking testbench for the continuous weight frame transmitter
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checked++; if ((ex) !== (got)) begin err_count++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o;
   wire serial_tx_o;
   wire frame_active_o;
   wire [6:0] rx_data;
   wire rx_valid;
   wire rx_bad;
   logic [5:0] bclk = 6'd1;
   logic [6:0] rx_q[$];
   logic [31:0] rd;
   integer err_count = 0;
   integer checked = 0;
   continuous_weight_frame_tx #(.CLK_HZ(9600)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .serial_tx_o(serial_tx_o), .frame_active_o(frame_active_o));
   serial_rx_model u_host (.clk_i(clk_i), .rx_i(serial_tx_o), .bit_clks_i(bclk),
      .data_o(rx_data), .valid_o(rx_valid), .bad_o(rx_bad));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (rx_valid === 1'b1) begin
         rx_q.push_back(rx_data);
         `CHK("framing", 1'b0, rx_bad)
      end
   end
   task complete_run;
      begin
         if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task fail_wait;
      begin
         err_count++;
         $display("BAD wait exp done got timeout");
         complete_run;
      end
   endtask
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
         end
         if (n == 50) fail_wait;
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
      end
   endtask
   task automatic wait_idle;
      integer n;
      begin
         for (n = 0; n < 20000 && frame_active_o !== 1'b0; n++) @(posedge clk_i);
         if (n == 20000) fail_wait;
      end
   endtask
   task automatic run_record(input logic stx, ck, sp, input logic [3:0] sel,
      input logic [31:0] scale, flags, w, t);
      logic [6:0] e[$];
      logic [6:0] s;
      logic [3:0] d;
      logic blank;
      integer i, n, u;
      begin
         wb_cycle(1'b1, 8'h04, scale);
         wb_cycle(1'b1, 8'h08, flags);
         wb_cycle(1'b1, 8'h0c, w);
         wb_cycle(1'b1, 8'h10, t);
         bclk = 6'd32 >> sel;
         rx_q.delete();
         // Enable dropped before the first record ends, so exactly one record is sent
         wb_cycle(1'b1, 8'h00, {24'h0, sel, sp, ck, stx, 1'b1});
         wb_cycle(1'b1, 8'h00, {24'h0, sel, sp, ck, stx, 1'b0});
         wait_idle;
         repeat (4) @(posedge clk_i);
         wb_cycle(1'b0, 8'h14, 32'h0);
         `CHK("status idle", 8'h00, {rd[12:7], rd[1:0]})
         if (stx) e.push_back(7'h02);
         e.push_back({sp, 1'b1, sp ? scale[6:5] : scale[4:3], scale[2:0]});
         e.push_back({sp ? flags[6] : flags[7], 1'b1, flags[4] | flags[5], flags[3:0]});
         e.push_back({3'b010, flags[8], 3'b000});
         u = (scale[2:0] >= 3 && scale[2:0] <= 5) ? 7 - scale[2:0] : 5;
         for (n = 0; n < 2; n++) begin
            blank = 1'b1;
            for (i = 0; i < 6; i++) begin
               d = (n ? t : w) >> (20 - 4 * i);
               if (blank && d == 4'h0 && i < u) begin
                  e.push_back(7'h20);
               end else begin
                  blank = 1'b0;
                  e.push_back(7'h30 + d);
               end
            end
         end
         e.push_back(7'h0d);
         s = 7'h00;
         foreach (e[i]) s = s + e[i];
         if (ck) e.push_back(7'h00 - s);
         `CHK("count", e.size(), rx_q.size())
         for (i = 0; i < e.size() && i < rx_q.size(); i++)
            `CHK("char", e[i], rx_q[i])
      end
   endtask
   task sc_regs;
      begin
         wb_cycle(1'b0, 8'h00, 32'h0);
         `CHK("ctrl", 32'h51, rd)
         wb_cycle(1'b0, 8'h04, 32'h0);
         `CHK("scale", 32'h12, rd)
         wb_cycle(1'b0, 8'h08, 32'h0);
         `CHK("flags", 32'h80, rd)
         wb_cycle(1'b1, 8'h3c, 32'hffff_ffff);
         wb_cycle(1'b0, 8'h3c, 32'h0);
         `CHK("unmapped", 32'h0, rd)
         wb_cycle(1'b1, 8'h00, 32'h50);
         wait_idle;
      end
   endtask
   task sc_plain;
      run_record(1'b0, 1'b0, 1'b0, 4'h5, 32'h0a, 32'h11, 32'h000120, 32'h0);
   endtask
   task sc_full;
      begin
         run_record(1'b1, 1'b1, 1'b1, 4'h5, 32'h44, 32'h16e, 32'h001234, 32'h000050);
         wb_cycle(1'b0, 8'h08, 32'h0);
         `CHK("print clear", 32'h6e, rd)
      end
   endtask
   task sc_slow;
      run_record(1'b1, 1'b0, 1'b0, 4'h0, 32'h1d, 32'h80, 32'h000005, 32'h100000);
   endtask
   task sc_zero;
      run_record(1'b0, 1'b1, 1'b0, 4'h3, 32'h11, 32'h0, 32'h0, 32'h0);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      sc_regs;
      sc_plain;
      sc_full;
      sc_slow;
      sc_zero;
      complete_run;
   end
endmodule // tb_top
